// ---- rtl/dlb_consts.svh ----
/*
 constants for the ds1 loopback and alarm controller: timing, detector thresholds
 and data link message codes.
 assumes a 250 mhz system clock and a link clock at the ds1 line rate.
*/
`ifndef DLB_CONSTS_SVH
`define DLB_CONSTS_SVH

// ****************************************************************
// timing
// ****************************************************************
`define DLB_CLK_HZ 250000000
`define DLB_CODE_HOLD_S 5

// ****************************************************************
// in-band code detector
// ****************************************************************
`define DLB_WIN_LAST 11'h3ff
`define DLB_ACT_TAP 4
`define DLB_DEACT_TAP 2
`define DLB_MISS_MAX 11'h010
`define DLB_ACT_ONES_LO 11'h0b4
`define DLB_ACT_ONES_HI 11'h0e6
`define DLB_DEACT_ONES_LO 11'h136
`define DLB_DEACT_ONES_HI 11'h174

// ****************************************************************
// data link bit-patterned messages
// ****************************************************************
`define DLB_MSG_TAIL 8'hff
`define DLB_CODE_LINE_ACT 6'h07
`define DLB_CODE_LINE_DEACT 6'h1c
`define DLB_CODE_PAY_ACT 6'h0a
`define DLB_CODE_PAY_DEACT 6'h19
`define DLB_CODE_UNIV_DEACT 6'h12
`define DLB_MSG_ACCEPT 4'h4
`define DLB_MSG_GAP_LAST 4'hf
`define DLB_IDLE_FLAG 8'h7e
`define DLB_IDLE_GUARD 4'h8

`endif

// ---- rtl/dlb_dl_cmd.sv ----
/*
 data link command message and idle code watcher, link clock domain.
 assumes rx_dlslot, prm_frame and prm_good come from logic on the link clock.
*/
`timescale 1ns/1ps
`include "dlb_consts.svh"

module dlb_dl_cmd (
   input wire logic lclk,
   input wire logic lrst_n,
   input wire logic rx_bit,
   input wire logic rx_dlslot,
   input wire logic prm_frame,
   input wire logic prm_good,
   output dlb_pkg::dlb_evt_s evt_tgl_r
);

   // ****************************************************************
   // message matching
   // ****************************************************************
   logic [15:0] sr_r;
   logic [5:0] cur_r;
   logic [3:0] run_r;
   logic [3:0] gap_r;
   logic armed_r;
   logic broken_r;
   logic [3:0] guard_r;

   function automatic logic is_flag_rot(input logic [7:0] v);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (v == ((`DLB_IDLE_FLAG >> i) | (`DLB_IDLE_FLAG << (8 - i)))) begin
            hit = 1'b1;
         end
      end
      is_flag_rot = hit;
   endfunction : is_flag_rot

   // all-ones octet then code octet, first bit lands in sr[0]
   wire logic [15:0] sr_nxt = {rx_bit, sr_r[15:1]};
   wire logic msg_hit = (sr_nxt[7:0] == `DLB_MSG_TAIL) && !sr_nxt[15] && !sr_nxt[8];
   wire logic [5:0] code = sr_nxt[14:9];
   wire logic same_hit = msg_hit && (gap_r == `DLB_MSG_GAP_LAST) && (code == cur_r)
                         && (run_r != 4'h0);
   wire logic run_end = rx_dlslot && (run_r != 4'h0) && (gap_r == `DLB_MSG_GAP_LAST)
                        && !same_hit;
   wire logic accepted = (run_r >= `DLB_MSG_ACCEPT);
   wire logic deact_now = rx_dlslot && same_hit && (run_r == `DLB_MSG_ACCEPT - 4'h1);
   wire logic idle_bad = !is_flag_rot(sr_nxt[15:8]);

   // activation taken at the end of the preamble
   dlb_pkg::dlb_evt_s pulse;
   always_comb begin
      pulse = '0;
      pulse.line_act = run_end && accepted && (cur_r == `DLB_CODE_LINE_ACT);
      pulse.pay_act = run_end && accepted && (cur_r == `DLB_CODE_PAY_ACT);
      pulse.line_deact = deact_now && (cur_r == `DLB_CODE_LINE_DEACT);
      pulse.pay_deact = deact_now && (cur_r == `DLB_CODE_PAY_DEACT);
      pulse.univ_deact = deact_now && (cur_r == `DLB_CODE_UNIV_DEACT);
      pulse.prm_deact = prm_good && armed_r && !broken_r;
   end

   always_ff @(posedge lclk or negedge lrst_n) begin
      if (!lrst_n) begin
         sr_r <= 16'h0000;
         cur_r <= 6'h00;
         run_r <= 4'h0;
         gap_r <= 4'h0;
      end else if (rx_dlslot) begin
         sr_r <= sr_nxt;
         if (same_hit) begin
            gap_r <= 4'h0;
            run_r <= (run_r == 4'hf) ? run_r : run_r + 4'h1;
         end else if (msg_hit) begin
            gap_r <= 4'h0;
            cur_r <= code;
            run_r <= 4'h1;
         end else begin
            gap_r <= gap_r + 4'h1;
            run_r <= run_end ? 4'h0 : run_r;
         end
      end
   end

   // ****************************************************************
   // idle code between performance reports
   // ****************************************************************
   always_ff @(posedge lclk or negedge lrst_n) begin
      if (!lrst_n) begin
         armed_r <= 1'b0;
         broken_r <= 1'b0;
         guard_r <= 4'h0;
      end else if (prm_good) begin
         armed_r <= 1'b1;
         broken_r <= 1'b0;
         guard_r <= `DLB_IDLE_GUARD;
      end else if (rx_dlslot) begin
         if (guard_r != 4'h0) begin
            guard_r <= guard_r - 4'h1;
         end else if (armed_r && !prm_frame && idle_bad) begin
            broken_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge lclk or negedge lrst_n) begin
      if (!lrst_n) begin
         evt_tgl_r <= '0;
      end else begin
         evt_tgl_r <= evt_tgl_r ^ pulse;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   // activation only after an accepted run
   act_after_run_a: assert property (@(posedge lclk) disable iff (!lrst_n)
      ($changed(evt_tgl_r.line_act) || $changed(evt_tgl_r.pay_act))
      |-> ($past(run_r) >= `DLB_MSG_ACCEPT) && (run_r == 4'h0))
      else $error("activation without accepted preamble");

endmodule : dlb_dl_cmd

// ---- rtl/dlb_inband_det.sv ----
/*
 in-band repeating code detector on the received line, link clock domain.
 assumes rx_bit and rx_fslot come from logic on the link clock.
*/
`timescale 1ns/1ps
`include "dlb_consts.svh"

module dlb_inband_det (
   input wire logic lclk,
   input wire logic lrst_n,
   input wire logic rx_bit,
   input wire logic rx_fslot,
   output logic act_win_r,
   output logic deact_win_r
);

   // ****************************************************************
   // pattern history and window counters
   // ****************************************************************
   logic [7:0] hist_r;
   logic [10:0] bit_cnt_r;
   logic [10:0] miss5_r;
   logic [10:0] miss3_r;
   logic [10:0] ones_r;

   function automatic logic in_range(input logic [10:0] v, input logic [10:0] lo,
                                     input logic [10:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction : in_range

   wire logic cnt_en = !rx_fslot;
   wire logic win_end = (bit_cnt_r == `DLB_WIN_LAST);
   wire logic miss5 = rx_bit ^ hist_r[`DLB_ACT_TAP];
   wire logic miss3 = rx_bit ^ hist_r[`DLB_DEACT_TAP];
   wire logic act_ok = (miss5_r < `DLB_MISS_MAX)
                       && in_range(ones_r, `DLB_ACT_ONES_LO, `DLB_ACT_ONES_HI);
   wire logic deact_ok = (miss3_r < `DLB_MISS_MAX)
                         && in_range(ones_r, `DLB_DEACT_ONES_LO, `DLB_DEACT_ONES_HI);

   // ****************************************************************
   // window evaluation, framing slots skipped
   // ****************************************************************
   always_ff @(posedge lclk or negedge lrst_n) begin
      if (!lrst_n) begin
         hist_r <= 8'h00;
         bit_cnt_r <= 11'h000;
         miss5_r <= 11'h000;
         miss3_r <= 11'h000;
         ones_r <= 11'h000;
         act_win_r <= 1'b0;
         deact_win_r <= 1'b0;
      end else begin
         hist_r <= {hist_r[6:0], rx_bit};
         if (cnt_en && win_end) begin
            bit_cnt_r <= 11'h000;
            miss5_r <= 11'h000;
            miss3_r <= 11'h000;
            ones_r <= 11'h000;
            act_win_r <= act_ok;
            deact_win_r <= deact_ok;
         end else if (cnt_en) begin
            bit_cnt_r <= bit_cnt_r + 11'h001;
            miss5_r <= miss5_r + {10'h000, miss5};
            miss3_r <= miss3_r + {10'h000, miss3};
            ones_r <= ones_r + {10'h000, rx_bit};
         end
      end
   end

endmodule : dlb_inband_det

// ---- rtl/dlb_loopback_ctrl.sv ----
/*
 ds1 customer-side loopback and alarm controller: loopback state, in-band and
 data link control, alarm indication and the transmit selection toward the network.
 assumes a framer on the link clock that marks framing and data link slots and a
 report receiver on the link clock that flags performance reports; esf_mode, ais_in and src_lost are asynchronous.
*/
//
// Overview of operation
// - alarm indication is unframed all ones
// - send alarm on source loss or disruption
// - never originate sectionalization alarm variants
// - customer alarm variant handled as plain AIS
// - customer remote variant handled as plain RAI
// - line loopback always, payload only in ESF
// - line loopback returns whole received signal
// - payload loopback returns payload, timing locked
// - payload loopback regenerates framing, reports flagged
// - only customer side obeys in-band codes
// - ESF activation only via data link messages
// - activation messages never echoed to network
// - end of preamble is the request
// - matching deactivate message releases loopback
// - in ESF, universal deactivate or AIS releases loopback
// - report, unbroken idle, report releases loopback
// - idle data link carries flag repetitions
// - message is all-ones octet then code octet
`timescale 1ns/1ps
`include "dlb_consts.svh"

module dlb_loopback_ctrl #(
   parameter logic [31:0] CODE_HOLD_CYC = 32'(`DLB_CODE_HOLD_S * `DLB_CLK_HZ)
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic lclk,
   input wire logic esf_mode,
   input wire logic ais_in,
   input wire logic src_lost,
   input wire logic rx_bit,
   input wire logic rx_fslot,
   input wire logic rx_dlslot,
   input wire logic prm_frame,
   input wire logic prm_good,
   input wire logic tx_bit_local,
   input wire logic tx_fbit_local,
   output dlb_pkg::dlb_lb_e lb_mode_r,
   output logic net_tx_r,
   output logic eq_rx_r,
   output logic net_ais_r,
   output logic prm_lb_r
);

   // ****************************************************************
   // link domain reset
   // ****************************************************************
   logic [1:0] lrst_pipe_r;
   wire logic lrst_n = lrst_pipe_r[1];

   always_ff @(posedge lclk or negedge rst_n) begin
      if (!rst_n) begin
         lrst_pipe_r <= 2'h0;
      end else begin
         lrst_pipe_r <= {lrst_pipe_r[0], 1'b1};
      end
   end

   // ****************************************************************
   // link domain detectors
   // ****************************************************************
   logic act_win;
   logic deact_win;
   dlb_pkg::dlb_evt_s evt_tgl;

   dlb_inband_det u_inband (
      .lclk(lclk),
      .lrst_n(lrst_n),
      .rx_bit(rx_bit),
      .rx_fslot(rx_fslot),
      .act_win_r(act_win),
      .deact_win_r(deact_win)
   );

   dlb_dl_cmd u_dl_cmd (
      .lclk(lclk),
      .lrst_n(lrst_n),
      .rx_bit(rx_bit),
      .rx_dlslot(rx_dlslot),
      .prm_frame(prm_frame),
      .prm_good(prm_good),
      .evt_tgl_r(evt_tgl)
   );

   // ****************************************************************
   // crossings into the system clock
   // ****************************************************************
   dlb_pkg::dlb_evt_s evt_s1_r;
   dlb_pkg::dlb_evt_s evt_s2_r;
   dlb_pkg::dlb_evt_s evt_s3_r;
   logic [3:0] lvl_s1_r;
   logic [3:0] lvl_s2_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         evt_s1_r <= '0;
         evt_s2_r <= '0;
         evt_s3_r <= '0;
         lvl_s1_r <= 4'h0;
         lvl_s2_r <= 4'h0;
      end else begin
         evt_s1_r <= evt_tgl;
         evt_s2_r <= evt_s1_r;
         evt_s3_r <= evt_s2_r;
         lvl_s1_r <= {act_win, deact_win, esf_mode, ais_in};
         lvl_s2_r <= lvl_s1_r;
      end
   end

   wire dlb_pkg::dlb_evt_s evp = evt_s2_r ^ evt_s3_r;
   wire logic act_q = lvl_s2_r[3];
   wire logic deact_q = lvl_s2_r[2];
   wire logic esf_q = lvl_s2_r[1];
   // only the plain AIS defect is looked at
   // no remote alarm variant decoded here
   wire logic ais_q = lvl_s2_r[0];

   // ****************************************************************
   // in-band code persistence
   // ****************************************************************
   dlb_pkg::dlb_code_e code_r;
   logic [31:0] code_cnt_r;

   wire dlb_pkg::dlb_code_e code_now = act_q ? dlb_pkg::CODE_ACT :
                                      deact_q ? dlb_pkg::CODE_DEACT : dlb_pkg::CODE_NONE;
   wire logic code_same = (code_now == code_r) && (code_r != dlb_pkg::CODE_NONE);
   // code held for the full interval
   wire logic code_fire = code_same && (code_cnt_r == CODE_HOLD_CYC - 32'h1);
   // in-band codes acted on, customer side only
   wire logic sf_act = !esf_q && code_fire && (code_r == dlb_pkg::CODE_ACT);
   wire logic sf_deact = !esf_q && code_fire && (code_r == dlb_pkg::CODE_DEACT);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         code_r <= dlb_pkg::CODE_NONE;
         code_cnt_r <= 32'h0;
      end else begin
         code_r <= code_now;
         if (!code_same) begin
            code_cnt_r <= 32'h0;
         end else if (code_cnt_r < CODE_HOLD_CYC) begin
            code_cnt_r <= code_cnt_r + 32'h1;
         end
      end
   end

   // ****************************************************************
   // loopback state
   // ****************************************************************
   dlb_pkg::dlb_lb_e lb_nxt;

   // in ESF only data link messages and incoming AIS act
   wire logic esf_line_act = esf_q && evp.line_act;
   wire logic esf_pay_act = esf_q && evp.pay_act;
   wire logic esf_any_rel = esf_q && (evp.univ_deact || evp.prm_deact || ais_q);
   wire logic esf_line_rel = esf_any_rel || (esf_q && evp.line_deact);
   wire logic esf_pay_rel = esf_any_rel || (esf_q && evp.pay_deact);

   always_comb begin
      lb_nxt = lb_mode_r;
      case (lb_mode_r)
         dlb_pkg::LB_NONE: begin
            if (sf_act || esf_line_act) begin
               lb_nxt = dlb_pkg::LB_LINE;
            end else if (esf_pay_act) begin
               lb_nxt = dlb_pkg::LB_PAYLOAD;
            end
         end
         dlb_pkg::LB_LINE: begin
            if (sf_deact || esf_line_rel) begin
               lb_nxt = dlb_pkg::LB_NONE;
            end
         end
         dlb_pkg::LB_PAYLOAD: begin
            if (!esf_q || esf_pay_rel) begin
               lb_nxt = dlb_pkg::LB_NONE;
            end
         end
         default: begin
            lb_nxt = dlb_pkg::LB_NONE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lb_mode_r <= dlb_pkg::LB_NONE;
      end else begin
         lb_mode_r <= lb_nxt;
      end
   end

   // ****************************************************************
   // crossings into the link clock
   // ****************************************************************
   logic [2:0] lnk_s1_r;
   logic [2:0] lnk_s2_r;

   always_ff @(posedge lclk or negedge lrst_n) begin
      if (!lrst_n) begin
         lnk_s1_r <= 3'h0;
         lnk_s2_r <= 3'h0;
      end else begin
         lnk_s1_r <= {lb_mode_r, src_lost};
         lnk_s2_r <= lnk_s1_r;
      end
   end

   wire logic line_l = (dlb_pkg::dlb_lb_e'(lnk_s2_r[2:1]) == dlb_pkg::LB_LINE);
   wire logic pay_l = (dlb_pkg::dlb_lb_e'(lnk_s2_r[2:1]) == dlb_pkg::LB_PAYLOAD);
   wire logic lost_l = lnk_s2_r[0];

   // ****************************************************************
   // transmit selection
   // ****************************************************************
   // payload with regenerated framing slot
   // received data link never returned in payload loop
   wire logic pay_bit = rx_fslot ? tx_fbit_local : rx_bit;
   // alarm on source loss when not looped
   wire logic ais_l = lost_l && !line_l && !pay_l;
   // whole received signal in line loopback
   // all ones with no framing slot kept
   wire logic net_nxt = line_l ? rx_bit : pay_l ? pay_bit : ais_l ? 1'b1 : tx_bit_local;
   // line loopback disrupts service, alarm toward equipment
   wire logic eq_nxt = line_l ? 1'b1 : rx_bit;

   always_ff @(posedge lclk or negedge lrst_n) begin
      if (!lrst_n) begin
         net_tx_r <= 1'b1;
         eq_rx_r <= 1'b1;
         net_ais_r <= 1'b0;
         prm_lb_r <= 1'b0;
      end else begin
         net_tx_r <= net_nxt;
         eq_rx_r <= eq_nxt;
         net_ais_r <= ais_l;
         prm_lb_r <= pay_l;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   pay_needs_esf_a: assert property (
      (lb_mode_r == dlb_pkg::LB_PAYLOAD && !esf_q) |=> (lb_mode_r == dlb_pkg::LB_NONE))
      else $error("payload loopback kept outside ESF");

   sf_hold_time_a: assert property (
      (lb_mode_r == dlb_pkg::LB_NONE && !esf_q && lb_nxt == dlb_pkg::LB_LINE)
      |-> (code_cnt_r == CODE_HOLD_CYC - 32'h1) && act_q && $past(act_q))
      else $error("in-band activation before hold time");

   esf_act_line_a: assert property (
      (lb_mode_r == dlb_pkg::LB_NONE && esf_q && $past(esf_q) && evp.line_act)
      |=> (lb_mode_r == dlb_pkg::LB_LINE))
      else $error("line activation request not taken");

   ais_release_a: assert property (
      (esf_q && ais_q && lb_mode_r != dlb_pkg::LB_NONE) |=> (lb_mode_r == dlb_pkg::LB_NONE))
      else $error("loopback kept under incoming AIS");

   univ_release_a: assert property (
      (esf_q && evp.univ_deact) |=> (lb_mode_r == dlb_pkg::LB_NONE))
      else $error("universal deactivate ignored");

   prm_release_a: assert property (
      (esf_q && evp.prm_deact) |=> (lb_mode_r == dlb_pkg::LB_NONE))
      else $error("report and idle release ignored");

   line_deact_a: assert property (
      (esf_q && lb_mode_r == dlb_pkg::LB_LINE && evp.line_deact)
      |=> (lb_mode_r == dlb_pkg::LB_NONE))
      else $error("line deactivate message ignored");

   sf_no_msg_a: assert property (
      (!esf_q && lb_mode_r == dlb_pkg::LB_NONE && !code_fire) |=> (lb_mode_r == dlb_pkg::LB_NONE))
      else $error("SF loopback without in-band code");

   line_echo_a: assert property (@(posedge lclk) disable iff (!lrst_n)
      line_l |=> (net_tx_r == $past(rx_bit)) && eq_rx_r)
      else $error("line loopback does not return received bit");

   ais_ones_a: assert property (@(posedge lclk) disable iff (!lrst_n)
      net_ais_r |-> net_tx_r)
      else $error("alarm indication bit not one");

   pay_frame_a: assert property (@(posedge lclk) disable iff (!lrst_n)
      (pay_l && rx_fslot) |=> (net_tx_r == $past(tx_fbit_local)) && prm_lb_r)
      else $error("payload loopback framing slot not regenerated");

   sf_line_c: cover property (sf_act ##1 lb_mode_r == dlb_pkg::LB_LINE);
   esf_pay_c: cover property (esf_pay_act ##1 lb_mode_r == dlb_pkg::LB_PAYLOAD);
   prm_rel_c: cover property (lb_mode_r != dlb_pkg::LB_NONE && esf_q && evp.prm_deact);
   ais_send_c: cover property (@(posedge lclk) disable iff (!lrst_n) $rose(net_ais_r));

endmodule : dlb_loopback_ctrl

// ---- rtl/dlb_pkg.sv ----
/*
 types shared by the ds1 loopback and alarm controller.
 assumes nothing of its surroundings.
*/
package dlb_pkg;

   // ****************************************************************
   // loopback state and in-band code kind
   // ****************************************************************
   typedef enum logic [1:0] {LB_NONE, LB_LINE, LB_PAYLOAD} dlb_lb_e;
   typedef enum logic [1:0] {CODE_NONE, CODE_ACT, CODE_DEACT} dlb_code_e;

   // ****************************************************************
   // data link command events, one bit each
   // ****************************************************************
   typedef struct packed {
      logic line_act;
      logic pay_act;
      logic line_deact;
      logic pay_deact;
      logic univ_deact;
      logic prm_deact;
   } dlb_evt_s;

endpackage : dlb_pkg

// ---- tb/dlb_net_model.sv ----
/*
 network-side ds1 source: framed bits, data link messages and idle flags, in-band codes.
 assumes the bench drives esf, frame_len and pat_len and calls send for messages.
*/
`timescale 1ns/1ps
module dlb_net_model (
   input wire logic lclk,
   input wire logic esf,
   input wire logic [7:0] frame_len,
   input wire logic [2:0] pat_len,
   output logic rx_bit,
   output logic rx_fslot,
   output logic rx_dlslot
);
   // ****************************************************************
   // framing, data link and pattern
   // ****************************************************************
   logic [7:0] pos_r = 8'h00;
   logic frm_r = 1'b0;
   logic [3:0] idx_r = 4'h0;
   logic [2:0] pat_r = 3'h0;
   logic on_r = 1'b0;
   logic [15:0] msg = 16'hffff;
   logic dl_bit;
   int reps = 0;
   // no alarm variant sent, only plain line content
   logic [7:0] idle = 8'h7e;
   task automatic send(input logic [5:0] code, input int n);
      msg = {1'b0, code, 1'b0, 8'hff};
      reps = n;
   endtask : send
   assign rx_fslot = (pos_r == 8'h00);
   assign rx_dlslot = esf && rx_fslot && frm_r;
   assign dl_bit = on_r ? msg[idx_r] : idle[idx_r[2:0]];
   assign rx_bit = rx_dlslot ? dl_bit : rx_fslot ? frm_r :
      (pat_len != 3'h0) ? (pat_r == pat_len - 3'h1) : (pos_r[0] ^ pos_r[2]);
   always @(posedge lclk) begin
      pos_r <= (pos_r >= frame_len - 8'h01) ? 8'h00 : pos_r + 8'h01;
      pat_r <= (pat_r >= pat_len - 3'h1) ? 3'h0 : pat_r + 3'h1;
      if (rx_fslot) frm_r <= ~frm_r;
      if (rx_dlslot) begin
         idx_r <= idx_r + 4'h1;
         if (idx_r == 4'hf) begin
            on_r <= reps > int'(on_r);
            reps <= reps - int'(on_r);
         end
      end
   end
endmodule : dlb_net_model

// ---- tb/tb_ds1_loopback_alarm_control.sv ----
/*
 self-checking bench for the loopback and alarm controller.
 assumes dlb_consts.svh on the include path and the network model beside it.
*/
`timescale 1ns/1ps
`include "dlb_consts.svh"
module tb_ds1_loopback_alarm_control;
   // ****************************************************************
   // clocks, stimulus and checks
   // ****************************************************************
   logic clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, esf_mode = 1'b1, ais_in = 1'b0;
   logic src_lost = 1'b0, m_esf = 1'b1, rx_bit, rx_fslot, rx_dlslot;
   logic prm_good = 1'b0;
   logic [7:0] m_len = 8'h02;
   logic [2:0] m_pat = 3'h0;
   logic net_tx_r, eq_rx_r, net_ais_r, prm_lb_r;
   dlb_pkg::dlb_lb_e lb_mode_r;
   int miscompares = 0, n_compared = 0;
   always #2 clk = ~clk;
   initial begin
      #1.3;
      forever #16 lclk = ~lclk;
   end
   dlb_loopback_ctrl #(.CODE_HOLD_CYC(32'd2000)) dut_u (.clk(clk), .rst_n(rst_n), .lclk(lclk),
      .esf_mode(esf_mode), .ais_in(ais_in), .src_lost(src_lost), .rx_bit(rx_bit),
      .rx_fslot(rx_fslot), .rx_dlslot(rx_dlslot), .prm_frame(1'b0), .prm_good(prm_good),
      .tx_bit_local(1'b0), .tx_fbit_local(~rx_bit), .lb_mode_r(lb_mode_r), .net_tx_r(net_tx_r),
      .eq_rx_r(eq_rx_r), .net_ais_r(net_ais_r), .prm_lb_r(prm_lb_r));
   dlb_net_model m_u (.lclk(lclk), .esf(m_esf), .frame_len(m_len), .pat_len(m_pat),
      .rx_bit(rx_bit), .rx_fslot(rx_fslot), .rx_dlslot(rx_dlslot));
   task automatic chk_mode(input dlb_pkg::dlb_lb_e got, input dlb_pkg::dlb_lb_e exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_mode
   task automatic chk_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic wait_mode(input dlb_pkg::dlb_lb_e exp, input int lim);
      for (int i = 0; i < lim && lb_mode_r !== exp; i++) @(negedge clk);
   endtask : wait_mode
   task automatic send_msg(input logic [5:0] code, input int n);
      m_u.send(code, n);
      wait (m_u.reps == 0);
   endtask : send_msg
   task automatic t_ais_src;
      @(negedge clk) src_lost = 1'b1;
      repeat (40) @(negedge clk);
      chk_bit(net_ais_r, 1'b1);
      chk_bit(net_tx_r, 1'b1);
      @(negedge clk) src_lost = 1'b0;
      repeat (40) @(negedge clk);
      chk_bit(net_ais_r, 1'b0);
   endtask : t_ais_src
   task automatic t_line_esf;
      logic b;
      m_u.send(`DLB_CODE_LINE_ACT, 10);
      repeat (2000) @(negedge clk);
      chk_mode(lb_mode_r, dlb_pkg::LB_NONE);
      chk_bit(net_tx_r, 1'b0);
      wait (m_u.reps == 0);
      wait_mode(dlb_pkg::LB_LINE, 1000);
      chk_mode(lb_mode_r, dlb_pkg::LB_LINE);
      repeat (40) @(negedge clk);
      for (int i = 0; i < 4; i++) begin
         @(negedge lclk) b = rx_bit;
         @(negedge lclk) chk_bit(net_tx_r, b);
      end
      chk_bit(eq_rx_r, 1'b1);
      send_msg(`DLB_CODE_LINE_DEACT, 5);
      wait_mode(dlb_pkg::LB_NONE, 3000);
      chk_mode(lb_mode_r, dlb_pkg::LB_NONE);
   endtask : t_line_esf
   task automatic t_pay_esf;
      logic b;
      send_msg(`DLB_CODE_PAY_ACT, 10);
      wait_mode(dlb_pkg::LB_PAYLOAD, 1000);
      chk_mode(lb_mode_r, dlb_pkg::LB_PAYLOAD);
      repeat (40) @(negedge clk);
      chk_bit(prm_lb_r, 1'b1);
      for (int i = 0; i < 8; i++) begin
         @(negedge lclk);
         if (i > 0) chk_bit(net_tx_r, b);
         b = rx_fslot ? ~rx_bit : rx_bit;
      end
      send_msg(`DLB_CODE_UNIV_DEACT, 5);
      wait_mode(dlb_pkg::LB_NONE, 3000);
      chk_mode(lb_mode_r, dlb_pkg::LB_NONE);
      send_msg(`DLB_CODE_PAY_ACT, 10);
      wait_mode(dlb_pkg::LB_PAYLOAD, 1000);
      chk_mode(lb_mode_r, dlb_pkg::LB_PAYLOAD);
      repeat (2) begin
         @(negedge lclk) prm_good = 1'b1;
         @(negedge lclk) prm_good = 1'b0;
         repeat (200) @(negedge lclk);
      end
      chk_mode(lb_mode_r, dlb_pkg::LB_NONE);
      send_msg(`DLB_CODE_PAY_ACT, 10);
      wait_mode(dlb_pkg::LB_PAYLOAD, 1000);
      @(negedge clk) ais_in = 1'b1;
      wait_mode(dlb_pkg::LB_NONE, 100);
      chk_mode(lb_mode_r, dlb_pkg::LB_NONE);
      @(negedge clk) ais_in = 1'b0;
   endtask : t_pay_esf
   task automatic t_refuse;
      send_msg(`DLB_CODE_LINE_ACT, 3);
      repeat (1000) @(negedge clk);
      chk_mode(lb_mode_r, dlb_pkg::LB_NONE);
      @(negedge clk) esf_mode = 1'b0;
      send_msg(`DLB_CODE_PAY_ACT, 10);
      repeat (1000) @(negedge clk);
      chk_mode(lb_mode_r, dlb_pkg::LB_NONE);
   endtask : t_refuse
   task automatic t_inband;
      @(negedge clk) m_esf = 1'b0;
      m_len = 8'hc1;
      m_pat = 3'h5;
      repeat (1000) @(negedge clk);
      chk_mode(lb_mode_r, dlb_pkg::LB_NONE);
      wait_mode(dlb_pkg::LB_LINE, 40000);
      chk_mode(lb_mode_r, dlb_pkg::LB_LINE);
      @(negedge clk) m_pat = 3'h3;
      wait_mode(dlb_pkg::LB_NONE, 40000);
      chk_mode(lb_mode_r, dlb_pkg::LB_NONE);
   endtask : t_inband
   task automatic results;
      if (miscompares == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      repeat (24) @(negedge clk);
      chk_mode(lb_mode_r, dlb_pkg::LB_NONE);
      t_ais_src;
      t_line_esf;
      t_pay_esf;
      t_refuse;
      t_inband;
      results;
   end
   initial begin
      #400000;
      miscompares++;
      results;
   end
endmodule : tb_ds1_loopback_alarm_control
